// ### bench/fetch_unit_model.sv
// behavioural fetch unit that hands the decoder one request per call
`timescale 1ns/1ns
module fetch_unit_model
(
    input wire logic clk,
    output logic reqValid,
    output logic [31:0] extField,
    output logic [3:0] regField,
    output logic [7:0] fourthByte,
    output logic testAndSet,
    output logic longStoreDisp32
);
    initial
    begin
        reqValid = 1'b0;
        extField = 32'h0;
        regField = 4'h0;
        fourthByte = 8'h0;
        testAndSet = 1'b0;
        longStoreDisp32 = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // on release reqValid drops and extField, regField and fourthByte are inverted so a stale value never looks valid; the two flags hold
    task automatic issue(input logic [31:0] ext, input logic [3:0] rf, input logic [7:0] fb,
        input logic test_and_set_instruction, input logic ls);
        @(posedge clk);
        #1;
        {reqValid, extField, regField, fourthByte, testAndSet, longStoreDisp32} = {1'b1, ext,
            rf, fb, test_and_set_instruction, ls};
        @(posedge clk);
        #1;
        {reqValid, extField, regField, fourthByte} = {1'b0, ~ext, ~rf, ~fb};
    endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the operand field decoder
`timescale 1ns/1ns
module testbench;
    import operand_field_decoder_pkg::*;
    logic clk, arst_n, reqValid, longStoreDisp32, testAndSet, outValid, upperHalf, lowByte;
    logic opcodeBit, tasRegDiscouraged;
    logic [31:0] extField, immediateOperand, absAddress, dispValue;
    logic [3:0] regField;
    logic [2:0] regNumber;
    logic [7:0] fourthByte, fourthByteDecoded;
    imm_width_t immSel;
    abs_width_t absSel;
    disp_width_t dispSel;
    op_size_t sizeSel;
    int errors, checkCount;
    fetch_unit_model i_fetch (.clk, .reqValid, .extField, .regField, .fourthByte, .testAndSet,
        .longStoreDisp32);
    operand_field_decoder i_dut (.clk, .arst_n, .reqValid, .immSel, .absSel, .dispSel, .sizeSel,
        .extField, .regField, .longStoreDisp32, .fourthByte, .testAndSet, .outValid,
        .immediateOperand, .absAddress, .dispValue, .regNumber, .upperHalf, .lowByte, .opcodeBit,
        .fourthByteDecoded, .tasRegDiscouraged);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // answer is due 1 ns after the taking edge, which registers it
    task automatic req(input logic [31:0] e, input logic [3:0] r, input logic [7:0] f,
        input logic t, input logic l);
        i_fetch.issue(e, r, f, t, l);
        check("outValid", {31'h0, outValid}, 32'h1);
    endtask
    task automatic widths();
        logic [31:0] ie [5] = '{32'h3, 32'h7, 32'h87, 32'hba87, 32'hfedcba87};
        logic [31:0] ae [5] = '{32'h87, 32'hba87, 32'hdcba87, 32'hfedcba87, 32'h87};
        logic [31:0] de [5] = '{32'hffffff87, 32'hffffba87, 32'hfedcba87, 32'hffffff87,
            32'hffffba87};
        for (int i = 0; i < 5; i++)
        begin
            immSel = imm_width_t'(i);
            absSel = abs_width_t'(i % 4);
            dispSel = disp_width_t'(i % 3);
            req(32'hfedcba87, 4'h0, 8'h0, 1'b0, 1'b0);
            check("immediateOperand", immediateOperand, ie[i]);
            check("absAddress", absAddress, ae[i]);
            check("dispValue", dispValue, de[i]);
        end
    endtask
    task automatic regs();
        for (int s = 0; s < 3; s++)
            for (int r = 0; r < 16; r++)
            begin
                sizeSel = op_size_t'(s);
                req(32'h0, 4'(r), 8'h0, 1'b0, 1'b0);
                check("regNumber", {29'h0, regNumber}, 32'(r % 8));
                check("upperHalf", {31'h0, upperHalf}, 32'(s == 1 && r > 7));
                check("lowByte", {31'h0, lowByte}, 32'(s == 0 && r > 7));
                check("opcodeBit", {31'h0, opcodeBit}, 32'(s == 2 && r > 7));
            end
    endtask
    task automatic specials();
        for (int i = 0; i < 16; i++)
        begin
            req(32'h0, 4'(i), {i[0], 7'h05}, i[3], i[1]);
            check("fourthByte", {24'h0, fourthByteDecoded}, {24'h0, i[0] & ~i[1], 7'h05});
            check("tasFlag", {31'h0, tasRegDiscouraged}, 32'(i[3] & i[1]));
        end
    endtask
    // reset in mid-run clears every output at once, then decoding resumes
    task automatic mid_reset();
        @(posedge clk);
        #1;
        arst_n = 1'b0;
        #1;
        check("outValid", {31'h0, outValid}, 32'h0);
        check("regNumber", {29'h0, regNumber}, 32'h0);
        check("fourthByteDecoded", {24'h0, fourthByteDecoded}, 32'h0);
        check("tasFlag", {31'h0, tasRegDiscouraged}, 32'h0);
        check("immediateOperand", immediateOperand, 32'h0);
        check("absAddress", absAddress, 32'h0);
        check("dispValue", dispValue, 32'h0);
        check("halfByteTop", {29'h0, upperHalf, lowByte, opcodeBit}, 32'h0);
        @(posedge clk);
        #1;
        arst_n = 1'b1;
        @(posedge clk);
        #1;
        check("outValid", {31'h0, outValid}, 32'h0);
        check("regNumber", {29'h0, regNumber}, 32'h0);
        immSel = IMM_8;
        sizeSel = SIZE_BYTE;
        req(32'h0000_01a5, 4'hd, 8'h80, 1'b0, 1'b0);
        check("immediateOperand", immediateOperand, 32'h0000_00a5);
        check("regNumber", {29'h0, regNumber}, 32'h5);
        check("lowByte", {31'h0, lowByte}, 32'h1);
        check("fourthByte", {24'h0, fourthByteDecoded}, 32'h80);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        arst_n = 1'b0;
        immSel = IMM_2;
        absSel = ABS_8;
        dispSel = DISP_8;
        sizeSel = SIZE_WORD;
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        widths();
        regs();
        specials();
        mid_reset();
        summarize();
    end
endmodule

// ### rtl/operand_field_decoder.sv
// operand field decoder: extension field widths and register field mapping
`timescale 1ns/1ns
`include "operand_field_decoder_defines.svh"

module operand_field_decoder
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reqValid,
    input wire operand_field_decoder_pkg::imm_width_t immSel,
    input wire operand_field_decoder_pkg::abs_width_t absSel,
    input wire operand_field_decoder_pkg::disp_width_t dispSel,
    input wire operand_field_decoder_pkg::op_size_t sizeSel,
    input wire logic [31:0] extField,
    input wire logic [3:0] regField,
    input wire logic longStoreDisp32,
    input wire logic [7:0] fourthByte,
    input wire logic testAndSet,
    output logic outValid,
    output logic [31:0] immediateOperand,
    output logic [31:0] absAddress,
    output logic [31:0] dispValue,
    output logic [2:0] regNumber,
    output logic upperHalf,
    output logic lowByte,
    output logic opcodeBit,
    output logic [7:0] fourthByteDecoded,
    output logic tasRegDiscouraged
);
    import operand_field_decoder_pkg::*;
    // registers that test-and-set may name without a warning: 0, 1, 4 and 5
    localparam logic [7:0] TasOkMask = `OFD_TAS_OK_MASK;

    typedef struct packed {
        logic valid;
        logic [31:0] immediate_operand;
        logic [31:0] abs;
        logic [31:0] disp;
        logic [2:0] regNum;
        logic upper;
        logic lowB;
        logic opBit;
        logic [7:0] byte4;
        logic tasWarn;
    } state_t;

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next = state_reg;
        state_next.valid = reqValid;
        if (reqValid)
        begin
            case (immSel)
                IMM_2: state_next.immediate_operand = extField & `OFD_MASK_2;
                IMM_3: state_next.immediate_operand = extField & `OFD_MASK_3;
                IMM_8: state_next.immediate_operand = extField & `OFD_MASK_8;
                IMM_16: state_next.immediate_operand = extField & `OFD_MASK_16;
                IMM_32: state_next.immediate_operand = extField & `OFD_MASK_32;
                default: state_next.immediate_operand = '0;
            endcase
            case (absSel)
                ABS_8: state_next.abs = extField & `OFD_MASK_8;
                ABS_16: state_next.abs = extField & `OFD_MASK_16;
                ABS_24: state_next.abs = extField & `OFD_MASK_24;
                ABS_32: state_next.abs = extField & `OFD_MASK_32;
                default: state_next.abs = '0;
            endcase
            // displacements are signed offsets from the base register
            case (dispSel)
                DISP_8: state_next.disp = {{24{extField[`OFD_SIGN_8]}}, extField[`OFD_SIGN_8:0]};
                DISP_16: state_next.disp = {{16{extField[`OFD_SIGN_16]}},
                    extField[`OFD_SIGN_16:0]};
                DISP_32: state_next.disp = extField;
                default: state_next.disp = '0;
            endcase
            // register number is always the low three bits of the nibble
            state_next.regNum = regField[`OFD_REG_NUM_MSB:0];
            state_next.opBit = 1'b0;
            state_next.upper = 1'b0;
            state_next.lowB = 1'b0;
            case (sizeSel)
                SIZE_WORD: state_next.upper = regField[`OFD_NIBBLE_TOP];
                SIZE_BYTE: state_next.lowB = regField[`OFD_NIBBLE_TOP];
                SIZE_LONG: state_next.opBit = regField[`OFD_NIBBLE_TOP];
                default: state_next.opBit = 1'b0;
            endcase
            state_next.byte4 = fourthByte;
            if (longStoreDisp32)
            begin
                state_next.byte4[`OFD_IGNORED_BIT] = 1'b0;
            end
            // advisory only: the instruction still decodes normally
            state_next.tasWarn = testAndSet &&
                !TasOkMask[regField[`OFD_REG_NUM_MSB:0]];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign outValid = state_reg.valid;
    assign immediateOperand = state_reg.immediate_operand;
    assign absAddress = state_reg.abs;
    assign dispValue = state_reg.disp;
    assign regNumber = state_reg.regNum;
    assign upperHalf = state_reg.upper;
    assign lowByte = state_reg.lowB;
    assign opcodeBit = state_reg.opBit;
    assign fourthByteDecoded = state_reg.byte4;
    assign tasRegDiscouraged = state_reg.tasWarn;

    ////////////////////////////////////////////////////////////////////////////
    a_imm_width: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && immSel == IMM_8 |=> outValid && immediateOperand[31:8] == 24'h0 &&
            immediateOperand[7:0] == $past(extField[7:0]))
        else $error("immediate width not applied");
    a_imm_small: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && immSel == IMM_2 |=> immediateOperand == ($past(extField) & 32'h0000_0003))
        else $error("two-bit immediate wrong");
    a_abs_width: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && absSel == ABS_24 |=> absAddress[31:24] == 8'h00 &&
            absAddress[23:0] == $past(extField[23:0]))
        else $error("absolute width not applied");
    a_disp_sign: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && dispSel == DISP_16 |=> dispValue[31:16] == {16{$past(extField[15])}} &&
            dispValue[15:0] == $past(extField[15:0]))
        else $error("displacement not sign extended");
    a_long_reg: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && sizeSel == SIZE_LONG |=> regNumber == $past(regField[2:0]) &&
            !upperHalf && !lowByte && opcodeBit == $past(regField[3]))
        else $error("long register mapping wrong");
    a_word_half: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && sizeSel == SIZE_WORD |=> upperHalf == $past(regField[3]) && !lowByte)
        else $error("word half select wrong");
    a_byte_lane: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && sizeSel == SIZE_BYTE |=> lowByte == $past(regField[3]) && !upperHalf)
        else $error("byte lane select wrong");
    a_ignored_bit: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && longStoreDisp32 |=> !fourthByteDecoded[7] &&
            fourthByteDecoded[6:0] == $past(fourthByte[6:0]))
        else $error("ignored bit leaked");
    a_tas_warn: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && testAndSet && regField[1] |=> tasRegDiscouraged)
        else $error("test-and-set register warning missing");
    a_hold_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !reqValid |=> !outValid && $stable(regNumber) && $stable(opcodeBit))
        else $error("outputs changed without request");
    // one property per width form, so a swapped mask is caught on its own
    a_imm_three: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && immSel == IMM_3 |=> immediateOperand == ($past(extField) & 32'h0000_0007))
        else $error("three-bit immediate wrong");
    a_imm_word: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && immSel == IMM_16 |=> immediateOperand == {16'h0000, $past(extField[15:0])})
        else $error("16-bit immediate wrong");
    a_imm_long: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && immSel == IMM_32 |=> immediateOperand == $past(extField))
        else $error("32-bit immediate wrong");
    a_abs_byte: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && absSel == ABS_8 |=> absAddress == {24'h00_0000, $past(extField[7:0])})
        else $error("8-bit absolute address wrong");
    a_abs_word: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && absSel == ABS_16 |=> absAddress == {16'h0000, $past(extField[15:0])})
        else $error("16-bit absolute address wrong");
    a_abs_long: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && absSel == ABS_32 |=> absAddress == $past(extField))
        else $error("32-bit absolute address wrong");
    a_disp_byte: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && dispSel == DISP_8 |=>
            dispValue == {{24{$past(extField[7])}}, $past(extField[7:0])})
        else $error("8-bit displacement wrong");
    a_disp_long: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && dispSel == DISP_32 |=> dispValue == $past(extField))
        else $error("32-bit displacement wrong");
    a_word_reg: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && sizeSel == SIZE_WORD |=>
            regNumber == $past(regField[2:0]) && !opcodeBit)
        else $error("word register number wrong");
    a_byte_reg: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && sizeSel == SIZE_BYTE |=>
            regNumber == $past(regField[2:0]) && !opcodeBit)
        else $error("byte register number wrong");
    a_fourth_pass: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && !longStoreDisp32 |=>
            fourthByteDecoded == $past(fourthByte))
        else $error("fourth byte altered outside long store");
    a_tas_ok: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && testAndSet && !regField[1] |=> !tasRegDiscouraged)
        else $error("test-and-set warning on allowed register");
    a_tas_off: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && !testAndSet |=> !tasRegDiscouraged)
        else $error("test-and-set warning without test-and-set");
    a_nibble_top: assert property (@(posedge clk) disable iff (!arst_n)
        reqValid && sizeSel != SIZE_LONG |=>
            !opcodeBit && regNumber == $past(regField[2:0]))
        else $error("nibble top bit handed back outside long size");
    a_data_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !reqValid |=>
            $stable(immediateOperand) && $stable(absAddress) && $stable(dispValue))
        else $error("operand outputs changed without request");
endmodule

// ### rtl/operand_field_decoder_defines.svh
// constants for the operand field decoder
`ifndef OPERAND_FIELD_DECODER_DEFINES_SVH
`define OPERAND_FIELD_DECODER_DEFINES_SVH
`define OFD_FIELD_W 32
`define OFD_REG_NUM_MSB 2
`define OFD_NIBBLE_TOP 3
`define OFD_IGNORED_BIT 7
`define OFD_MASK_2 32'h0000_0003
`define OFD_MASK_3 32'h0000_0007
`define OFD_MASK_8 32'h0000_00ff
`define OFD_MASK_16 32'h0000_ffff
`define OFD_MASK_24 32'h00ff_ffff
`define OFD_MASK_32 32'hffff_ffff
`define OFD_SIGN_8 7
`define OFD_SIGN_16 15
`define OFD_TAS_OK_MASK 8'h33
`endif

// ### rtl/operand_field_decoder_pkg.sv
// types shared by the operand field decoder
package operand_field_decoder_pkg;
    typedef enum logic [2:0] {
        IMM_2 = 3'h0,
        IMM_3 = 3'h1,
        IMM_8 = 3'h2,
        IMM_16 = 3'h3,
        IMM_32 = 3'h4
    } imm_width_t;
    typedef enum logic [1:0] {
        ABS_8 = 2'h0,
        ABS_16 = 2'h1,
        ABS_24 = 2'h2,
        ABS_32 = 2'h3
    } abs_width_t;
    typedef enum logic [1:0] {
        DISP_8 = 2'h0,
        DISP_16 = 2'h1,
        DISP_32 = 2'h2
    } disp_width_t;
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_LONG = 2'h2
    } op_size_t;
endpackage
